// [src/pucb_pkg.sv]
// constants, field layout and carrier types of the periodic serial block channel
package pucb_pkg;
  // clocking and line rate
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SRC_MHZ       = 20;
  localparam int SRC_PRESCALE  = 1;
  localparam int BRG_DIV       = 130;
  localparam int OVERSAMPLE    = 16;
  localparam int BIT_RATE_BPS  = 9615;
  localparam int BIT_TIME_US   = 104;
  localparam int OS_CYCLES     = CLK_MHZ * SRC_PRESCALE * BRG_DIV / SRC_MHZ;
  localparam int PERIOD_MS     = 5;
  localparam int PERIOD_CYCLES = PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // frame layout
  localparam logic [3:0] OS_LAST     = 4'hf;
  localparam logic [3:0] OS_MID      = 4'h7;
  localparam logic [3:0] TX_LAST_BIT = 4'ha;
  localparam logic [3:0] RX_STOP_BIT = 4'h9;
  // block buffers
  localparam int         BLOCK_LENGTH = 8;
  localparam logic [2:0] IDX_LAST     = 3'h7;
  // wishbone map
  localparam int         ADR_W     = 8;
  localparam int         DAT_W     = 32;
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] ISTAT_OFS = 8'h08;
  localparam logic [7:0] IMASK_OFS = 8'h0c;
  localparam logic [2:0] TXB_BLK   = 3'h1;
  localparam logic [2:0] RXB_BLK   = 3'h2;
  // field positions and reset values
  localparam int         CTRL_START  = 0;
  localparam int         CTRL_EN     = 1;
  localparam logic       START_RST   = 1'b0;
  localparam logic       EN_RST      = 1'b0;
  localparam int         STAT_TXIDX  = 0;
  localparam int         STAT_RXIDX  = 4;
  localparam int         STAT_TXBUSY = 8;
  localparam int         STAT_RXFULL = 9;
  localparam int         IRQ_TXDONE  = 0;
  localparam int         IRQ_RXDONE  = 1;
  localparam int         IRQ_RXERR   = 2;
  localparam logic [2:0] IRQ_RST     = 3'h0;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } pucb_err_t;

  typedef struct packed {
    pucb_err_t  err;
    logic [7:0] data;
  } pucb_rxent_t;
endpackage : pucb_pkg

// [src/pucb_div.sv]
// enable-driven modulo divider producing a one-cycle tick
`timescale 1ns/100ps
module pucb_div #(
  parameter int DIV = 2
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // count enable and output tick
  input  wire logic en_i,
  output logic      tick_o
);
  localparam int         W    = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (en_i) begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

  assign tick_o = en_i && (cnt_reg == LAST);
endmodule : pucb_div

// [src/pucb_top.sv]
// periodic 8-byte block serial channel with wishbone register access
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// - Each frame is eight data bits, an even parity bit and one stop bit, on both ends.
// - Data bits travel least significant bit first.
// - The line runs at 9615 bps, about 104 us per bit, both directions.
// - The bit clock is a 20 MHz source divided by one, then by 130, then by 16.
// - The baud rate generator counts the undivided source, not a prescaled one.
// - Bit timing is made inside the block; no external transfer clock is used.
// - A period timer paces all serial activity instead of channel interrupts; the receiver still decodes RXD_I frames without waiting for it.
// - Each 5 ms tick polls the receive holding register and sends one byte if active.
// - A waiting received byte is taken, stored at the receive index, and the index wraps after 8.
// - Bytes are sent from the 8-entry transmit buffer at the transmit index only while start is 1.
// - The transmit index advances by one per byte sent.
// - After 8 bytes the transmit index and start flag both return to zero.
// - Transmit, receive and receive error buffers each hold eight entries.
// - All receive error flags are captured together with the byte they belong to.
module pucb_top #(
  parameter int PERIOD_CYCLES = pucb_pkg::PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_I,
  // wishbone slave
  input  wire logic                       CYC_I,
  input  wire logic                       STB_I,
  input  wire logic                       WE_I,
  input  wire logic [pucb_pkg::ADR_W-1:0] ADR_I,
  input  wire logic [3:0]                 SEL_I,
  input  wire logic [pucb_pkg::DAT_W-1:0] DAT_I,
  output logic      [pucb_pkg::DAT_W-1:0] DAT_O,
  output logic                            ACK_O,
  // serial line
  input  wire logic                       RXD_I,
  output logic                            TXD_O,
  // interrupt
  output logic                            IRQ_O
);
  import pucb_pkg::*;

  typedef enum logic {TX_IDLE, TX_RUN} pucb_txst_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_WAIT} pucb_rxst_t;

  logic [7:0]        src_acc_reg;
  logic [8:0]        src_sum;
  logic              src_tick;
  logic              os_tick;
  logic              period_tick;
  logic              rxd_s1_reg;
  logic              rxd_s2_reg;
  logic              ack_reg;
  logic [31:0]       dat_reg;
  logic [31:0]       rd_data;
  logic              wb_hit;
  logic              wb_wr;
  logic [2:0]        adr_blk;
  logic [2:0]        adr_ent;
  logic              ctrl_wr;
  logic              tx_start_reg;
  logic              ctrl_en_reg;
  logic [2:0]        tx_idx_reg;
  logic [2:0]        rx_idx_reg;
  logic [7:0]        tx_buf_reg [BLOCK_LENGTH];
  pucb_rxent_t       rx_mem_reg [BLOCK_LENGTH];
  logic              launch;
  logic              take;
  pucb_txst_t        tx_state_reg;
  logic [10:0]       tx_shift_reg;
  logic [3:0]        tx_bits_reg;
  logic [3:0]        tx_os_reg;
  logic              txd_reg;
  pucb_rxst_t        rx_state_reg;
  logic [3:0]        rx_os_reg;
  logic [3:0]        rx_bits_reg;
  logic [8:0]        rx_shift_reg;
  logic              rx_done;
  pucb_rxent_t       rx_hold_reg;
  logic              rx_full_reg;
  logic [2:0]        irq_stat_reg;
  logic [2:0]        irq_mask_reg;
  logic [2:0]        irq_ev;
  logic              irq_reg;

  // 20 MHz count source as an average-rate enable on the 250 MHz clock
  assign src_sum  = {1'b0, src_acc_reg} + 9'(SRC_MHZ);
  assign src_tick = src_sum >= 9'(CLK_MHZ);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      src_acc_reg <= 8'h00;
    end else begin
      src_acc_reg <= src_tick ? 8'(src_sum - 9'(CLK_MHZ)) : src_sum[7:0];
    end
  end

  // baud generator gives the 16x sampling enable
  pucb_div #(.DIV(BRG_DIV)) u_brg (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .en_i   (src_tick),
    .tick_o (os_tick)
  );

  // period timer only runs while software enables the channel
  pucb_div #(.DIV(PERIOD_CYCLES)) u_period (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .en_i   (ctrl_en_reg),
    .tick_o (period_tick)
  );

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= RXD_I;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end

  // wishbone: ack one cycle after the strobe, writes land on the ack edge
  assign wb_hit  = CYC_I && STB_I;
  assign wb_wr   = wb_hit && WE_I && ack_reg && SEL_I[0];
  assign adr_blk = ADR_I[7:5];
  assign adr_ent = ADR_I[4:2];
  assign ctrl_wr = wb_wr && (ADR_I == CTRL_OFS);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_hit && !ack_reg;
      if (wb_hit && !ack_reg) begin
        dat_reg <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (adr_blk == TXB_BLK) begin
      rd_data[7:0] = tx_buf_reg[adr_ent];
    end else if (adr_blk == RXB_BLK) begin
      rd_data[10:0] = rx_mem_reg[adr_ent];
    end else begin
      case (ADR_I)
        CTRL_OFS: begin
          rd_data[CTRL_START] = tx_start_reg;
          rd_data[CTRL_EN]    = ctrl_en_reg;
        end
        STAT_OFS: begin
          rd_data[STAT_TXIDX +: 3] = tx_idx_reg;
          rd_data[STAT_RXIDX +: 3] = rx_idx_reg;
          rd_data[STAT_TXBUSY]     = (tx_state_reg == TX_RUN);
          rd_data[STAT_RXFULL]     = rx_full_reg;
        end
        ISTAT_OFS: rd_data[2:0] = irq_stat_reg;
        IMASK_OFS: rd_data[2:0] = irq_mask_reg;
        default:   rd_data = 32'h0000_0000;
      endcase
    end
  end

  // control; a software write wins over the end-of-block clear
  assign launch = period_tick && tx_start_reg && (tx_state_reg == TX_IDLE);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      tx_start_reg <= START_RST;
      ctrl_en_reg  <= EN_RST;
    end else if (ctrl_wr) begin
      tx_start_reg <= DAT_I[CTRL_START];
      ctrl_en_reg  <= DAT_I[CTRL_EN];
    end else if (launch && (tx_idx_reg == IDX_LAST)) begin
      tx_start_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      tx_idx_reg <= 3'h0;
    end else if (launch) begin
      tx_idx_reg <= (tx_idx_reg == IDX_LAST) ? 3'h0 : tx_idx_reg + 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < BLOCK_LENGTH; i++) begin
        tx_buf_reg[i] <= 8'h00;
      end
    end else if (wb_wr && (adr_blk == TXB_BLK)) begin
      tx_buf_reg[adr_ent] <= DAT_I[7:0];
    end
  end

  // transmitter: shift register holds start, data, parity and stop
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg  <= 4'h0;
      tx_os_reg    <= 4'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (launch) begin
            tx_shift_reg <= {1'b1, ^tx_buf_reg[tx_idx_reg], tx_buf_reg[tx_idx_reg], 1'b0};
            tx_bits_reg  <= 4'h0;
            tx_os_reg    <= 4'h0;
            tx_state_reg <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (os_tick) begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == OS_LAST) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              tx_bits_reg  <= tx_bits_reg + 4'h1;
              if (tx_bits_reg == TX_LAST_BIT) begin
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= (tx_state_reg == TX_RUN) ? tx_shift_reg[0] : 1'b1;
    end
  end

  // receiver: a start bit must still be low at its middle, else it was a glitch
  assign rx_done = (rx_state_reg == RX_DATA) && os_tick && (rx_os_reg == OS_LAST)
                   && (rx_bits_reg == RX_STOP_BIT);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bits_reg  <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (!rxd_s2_reg) begin
            rx_os_reg    <= 4'h0;
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == OS_MID) begin
              rx_os_reg    <= 4'h0;
              rx_bits_reg  <= 4'h0;
              rx_state_reg <= rxd_s2_reg ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (os_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == OS_LAST) begin
              rx_bits_reg <= rx_bits_reg + 4'h1;
              if (rx_bits_reg == RX_STOP_BIT) begin
                // a low stop bit must end before a new start is armed
                rx_state_reg <= rxd_s2_reg ? RX_IDLE : RX_WAIT;
              end else begin
                rx_shift_reg <= {rxd_s2_reg, rx_shift_reg[8:1]};
              end
            end
          end
        end
        RX_WAIT: begin
          if (rxd_s2_reg) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // holding register; on overrun the older byte is kept and flagged
  assign take = period_tick && rx_full_reg;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rx_hold_reg <= '0;
      rx_full_reg <= 1'b0;
    end else if (rx_done && rx_full_reg && !take) begin
      rx_hold_reg.err.overrun <= 1'b1;
    end else if (rx_done) begin
      rx_hold_reg.data        <= rx_shift_reg[7:0];
      rx_hold_reg.err.parity  <= ^rx_shift_reg;
      rx_hold_reg.err.framing <= !rxd_s2_reg;
      rx_hold_reg.err.overrun <= 1'b0;
      rx_full_reg             <= 1'b1;
    end else if (take) begin
      rx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rx_idx_reg <= 3'h0;
      for (int i = 0; i < BLOCK_LENGTH; i++) begin
        rx_mem_reg[i] <= '0;
      end
    end else if (take) begin
      rx_mem_reg[rx_idx_reg] <= rx_hold_reg;
      rx_idx_reg <= (rx_idx_reg == IDX_LAST) ? 3'h0 : rx_idx_reg + 3'h1;
    end
  end

  // interrupt status: set wins over a write-one clear
  always_comb begin
    irq_ev             = 3'h0;
    irq_ev[IRQ_TXDONE] = launch && (tx_idx_reg == IDX_LAST);
    irq_ev[IRQ_RXDONE] = take && (rx_idx_reg == IDX_LAST);
    irq_ev[IRQ_RXERR]  = take && (|rx_hold_reg.err);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      if (wb_wr && (ADR_I == ISTAT_OFS)) begin
        irq_stat_reg <= (irq_stat_reg & ~DAT_I[2:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      if (wb_wr && (ADR_I == IMASK_OFS)) begin
        irq_mask_reg <= DAT_I[2:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign DAT_O = dat_reg;
  assign ACK_O = ack_reg;
  assign TXD_O = txd_reg;
  assign IRQ_O = irq_reg;

  // checking helpers
  logic [10:0] os_gap_reg;
  logic        os_seen_reg;
  logic [3:0]  src_gap_reg;

  // idle cycles since the last count source tick, saturating
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      src_gap_reg <= 4'h0;
    end else if (src_tick) begin
      src_gap_reg <= 4'h0;
    end else if (src_gap_reg != 4'hf) begin
      src_gap_reg <= src_gap_reg + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      os_gap_reg  <= 11'h000;
      os_seen_reg <= 1'b0;
    end else if (os_tick) begin
      os_gap_reg  <= 11'h000;
      os_seen_reg <= 1'b1;
    end else begin
      os_gap_reg <= os_gap_reg + 11'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  ack_single_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  src_spacing_a: assert property (src_tick |-> src_gap_reg >= 4'hb)
    else $error("count source ticks faster than 20 MHz");
  os_period_a: assert property (os_tick && os_seen_reg |-> os_gap_reg == 11'(OS_CYCLES - 1))
    else $error("16x enable spacing wrong");
  tx_idle_high_a: assert property (tx_state_reg == TX_IDLE |=> TXD_O)
    else $error("line not high while idle");
  tx_start_bit_a: assert property ($rose(tx_state_reg == TX_RUN) |=> !TXD_O)
    else $error("frame does not open with low start bit");
  tx_launch_a: assert property ($rose(tx_state_reg == TX_RUN)
                                |-> $past(period_tick && tx_start_reg))
    else $error("byte sent without tick and start flag");
  tx_index_a: assert property (launch && tx_idx_reg != IDX_LAST
                               |=> tx_idx_reg == $past(tx_idx_reg) + 3'h1)
    else $error("transmit index did not advance");
  tx_block_end_a: assert property (launch && tx_idx_reg == IDX_LAST && !ctrl_wr
                                   |=> !tx_start_reg && tx_idx_reg == 3'h0)
    else $error("block end did not clear index and start");
  rx_store_a: assert property (take |=> rx_mem_reg[$past(rx_idx_reg)] == $past(rx_hold_reg)
                               && (!rx_full_reg || $past(rx_done)))
    else $error("received byte and flags not stored together");
  rx_wrap_a: assert property (take && rx_idx_reg == IDX_LAST |=> rx_idx_reg == 3'h0)
    else $error("receive index did not wrap after eight");
  rx_parity_a: assert property (rx_done && !rx_full_reg
                                |=> rx_hold_reg.err.parity == $past(^rx_shift_reg))
    else $error("parity flag disagrees with received bits");

  tx_block_c: cover property (launch && tx_idx_reg == IDX_LAST);
  rx_block_c: cover property (take && rx_idx_reg == IDX_LAST);
  rx_parity_c: cover property (rx_done ##1 rx_hold_reg.err.parity);
  rx_overrun_c: cover property (rx_done && rx_full_reg && !take);
endmodule : pucb_top

// [tb/pucb_peer.sv]
// remote serial partner: decodes our transmit line, sends frames on receive line
`timescale 1ns/100ps
module pucb_peer
  import pucb_pkg::*;
#(
  parameter int BIT = OS_CYCLES * OVERSAMPLE
) (
  // clock
  input  wire logic clk_i,
  // serial line
  input  wire logic line_i,
  output logic      line_o
);
  logic [8:0] tx_q[$];
  time        tx_t[$];
  logic [7:0] d;
  logic       p;
  logic       ok;

  initial line_o = 1'b1;

  // one frame per falling edge, sampled at mid-bit
  always begin
    @(negedge line_i);
    tx_t.push_back($time);
    repeat (BIT / 2) @(posedge clk_i);
    ok = (line_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = line_i;
    end
    repeat (BIT) @(posedge clk_i);
    p = line_i;
    repeat (BIT) @(posedge clk_i);
    ok = ok && (line_i === 1'b1) && ((^d ^ p) === 1'b0);
    tx_q.push_back({ok, d});
  end

  // one frame plus one idle bit; the errors are only those asked for
  task automatic send(input logic [7:0] v, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ^v ^ bad_par, v, 1'b0};
    for (int i = 0; i < 12; i++) begin
      line_o <= (i < 11) ? f[i] : 1'b1;
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send
endmodule : pucb_peer

// [tb/periodic_uart_block_transfer_tb.sv]
// self-checking bench for the periodic serial block channel
`timescale 1ns/100ps
module periodic_uart_block_transfer_tb;
  import pucb_pkg::*;
  // period must exceed one frame so every tick can launch a byte
  localparam int PER = 300000;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we  = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0]       sel = 4'h0;
  logic [DAT_W-1:0] dat_w = '0;
  logic [DAT_W-1:0] dat_r;
  logic [DAT_W-1:0] rd;
  logic             ack;
  logic             rxd;
  logic             txd;
  logic             irq;
  int               error_cnt = 0;
  int               checks_done = 0;

  pucb_top #(.PERIOD_CYCLES(PER)) i_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .RXD_I(rxd), .TXD_O(txd), .IRQ_O(irq));
  pucb_peer i_peer (.clk_i(clk), .line_i(txd), .line_o(rxd));

  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  function automatic logic [7:0] txv(input int i);
    return 8'h5a ^ 8'(37 * i);
  endfunction : txv

  function automatic logic [7:0] rxv(input int i);
    return 8'hc3 + 8'(17 * i);
  endfunction : rxv

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // classic single cycle; ack is awaited, never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) chk(32'h0, 32'h1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // spaced reads so the bus does not swamp the run
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      repeat (500) @(posedge clk);
      wb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 4000);
    chk(rd & m, v);
  endtask : poll

  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    chk({31'h0, txd}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h60, 32'hff);
    wb(1'b0, 8'h60, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, STAT_OFS, 32'h3ff);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h20, 32'h1ab);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'hab);
  endtask : t_reset

  // timer frozen: two bytes pile up, the older one is kept
  task automatic t_overrun;
    i_peer.send(8'h11, 1'b0, 1'b0);
    i_peer.send(8'h22, 1'b0, 1'b0);
    wb(1'b0, STAT_OFS, 32'h0);
    chk({31'h0, rd[STAT_RXFULL]}, 32'h1);
    wb(1'b1, CTRL_OFS, 32'h2);
    poll(STAT_OFS, 32'h70, 32'h10);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h411);
    wb(1'b0, ISTAT_OFS, 32'h0);
    chk(rd, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, IMASK_OFS, 32'h4);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, ISTAT_OFS, 32'h4);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    chk(32'(i_peer.tx_t.size()), 32'h0);
  endtask : t_overrun

  // full duplex block; receive slots start at 1 after the overrun test
  task automatic t_block;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) wb(1'b1, 8'(32'h20 + 4 * i), {24'h0, txv(i)});
    wb(1'b1, IMASK_OFS, 32'h7);
    wb(1'b1, CTRL_OFS, 32'h3);
    fork
      for (int i = 0; i < 8; i++) i_peer.send(rxv(i), i == 2, i == 7);
      begin
        while (i_peer.tx_q.size() < 1) @(posedge clk);
        wb(1'b0, STAT_OFS, 32'h0);
        chk({29'h0, rd[2:0]}, 32'h1);
        while (i_peer.tx_q.size() < 8) @(posedge clk);
      end
    join
    for (int i = 0; i < 8; i++) begin
      chk({23'h0, i_peer.tx_q[i]}, {23'h0, 1'b1, txv(i)});
    end
    chk(32'(i_peer.tx_t[1] - i_peer.tx_t[0]), 32'(PER * CLK_PERIOD_NS));
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, STAT_OFS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0);
    poll(STAT_OFS, 32'h70, 32'h10);
    chk(32'(i_peer.tx_q.size()), 32'h8);
    for (int i = 0; i < 8; i++) begin
      e = {24'h0, rxv(i)} | ((i == 2) ? 32'h100 : 32'h0) | ((i == 7) ? 32'h200 : 32'h0);
      wb(1'b0, 8'(32'h40 + 4 * ((i + 1) % 8)), 32'h0);
      chk(rd, e);
    end
    wb(1'b0, ISTAT_OFS, 32'h0);
    chk(rd, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, ISTAT_OFS, 32'h7);
    wb(1'b0, ISTAT_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_block

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_overrun;
    t_block;
    give_verdict;
  end

  // whole run needs about four million cycles
  initial begin
    repeat (6000000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
endmodule : periodic_uart_block_transfer_tb
